// ---- inc/sys_cfg_pkg.sv ----
/*
  Package for the system bus configuration register bank: addresses, field
  positions, reset values and shared types.
  Assumes a CPU core that reaches the bank through 24-bit memory cycles.
*/
`default_nettype none
package sys_cfg_pkg;
  localparam int          ADDR_W          = 24;
  localparam logic [23:0] ADDR_BUS_CS     = 24'h00FF00;
  localparam logic [23:0] ADDR_STACK_PAGE = 24'h00FF01;
  localparam logic [23:0] ADDR_REL_WAIT   = 24'h00FF02;
  // Reset values, single-chip layout and processor layout
  localparam logic [7:0]  RST_BUS_CS_MCU  = 8'h30;
  localparam logic [7:0]  RST_BUS_CS_MPU  = 8'h31;
  localparam logic [7:0]  RST_STACK_PAGE  = 8'h00;
  localparam logic [7:0]  RST_REL_WAIT    = 8'h00;
  // Field positions
  localparam int BUS_MODE_HI_POS = 7;
  localparam int BUS_MODE_LO_POS = 6;
  localparam int CS_MODE_HI_POS  = 5;
  localparam int CS_MODE_LO_POS  = 4;
  localparam int REL_EN_POS      = 7;
  localparam int WAIT_LO_POS     = 4;
  localparam int CLK_SRC_POS     = 3;
  localparam int HS_OSC_POS      = 2;
  localparam int VOLT_LO_POS     = 0;
  // Wait states added per step of the wait code
  localparam logic [3:0]  WAIT_STEP       = 4'h2;

  typedef enum logic [1:0] {
    BUS_SINGLE, BUS_64K, BUS_512K_MIN, BUS_512K_MAX
  } bus_mode_t;

  typedef enum logic [1:0] {
    CS_8K, CS_16K, CS_32K, CS_64K
  } cs_mode_t;

  // CPU memory cycle towards the bank
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [ADDR_W-1:0]     addr;
    logic [7:0]            wdata;
  } cpu_req_t;

  // Decoded configuration seen by the rest of the chip
  typedef struct packed {
    bus_mode_t  busMode;
    cs_mode_t   csMode;
    logic [3:0] csEnable;
    logic [7:0] stackPage;
    logic [3:0] waitStates;
    logic       clkSrcHs;
    logic       hsOscOn;
    logic [1:0] voltMode;
  } sys_cfg_t;
endpackage : sys_cfg_pkg
`default_nettype wire

// ---- rtl/system_bus_config_registers.sv ----
/*
  System bus configuration register bank: three byte registers in the CPU
  memory map, interrupt gating until setup, and the bus release handshake.
  Assumes one system clock, an async active-low system reset, and that the
  external master's request and the straps are stable pins on the board.
*/
`default_nettype none
module system_bus_config_registers
  import sys_cfg_pkg::*;
#(
  parameter bit PROC_MODE     = 1'b0,  // 0 single-chip layout, 1 processor layout
  parameter bit CS_MODE_STORE = 1'b0,  // Chip-select mode field is storage only
  parameter bit HAS_RELEASE   = 1'b1   // Bus release pins are present
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire cpu_req_t cpuReq,
  output logic [7:0]    rdData,
  input  wire logic     intReqIn,
  input  wire logic     nmiReqIn,
  output logic          intReqOut,
  output logic          nmiReqOut,
  input  wire logic     busRequestIn_n,
  output logic          busAck_n,
  output logic          internalMemBlock,
  output logic          releasePinsUsed,
  output sys_cfg_t      sysCfg
);

  // Write and read selects
  wire selBusCs  = (cpuReq.addr == ADDR_BUS_CS);
  wire selStack  = (cpuReq.addr == ADDR_STACK_PAGE);
  wire selRel    = (cpuReq.addr == ADDR_REL_WAIT);
  wire wrBusCs   = cpuReq.wr && selBusCs;
  wire wrStack   = cpuReq.wr && selStack;
  wire wrRel     = cpuReq.wr && selRel;

  logic [7:0] busCs_ff;
  logic [7:0] stackPage_ff;
  logic [7:0] relWait_ff;
  logic       busCsWritten_ff;
  logic       stackWritten_ff;
  logic [2:0] reqSync_ff;
  logic       reqLevel_ff;
  logic       released_ff;

  // The reset value of the first register depends on the layout
  localparam logic [7:0] RST_BUS_CS = PROC_MODE ? RST_BUS_CS_MPU : RST_BUS_CS_MCU;

  // Register storage, byte wide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busCs_ff     <= RST_BUS_CS;
      stackPage_ff <= RST_STACK_PAGE;
      relWait_ff   <= RST_REL_WAIT;
    end else begin
      if (wrBusCs) busCs_ff <= cpuReq.wdata;
      if (wrStack) stackPage_ff <= cpuReq.wdata;
      if (wrRel)   relWait_ff <= cpuReq.wdata;
    end
  end

  // Written-once flags; sticky, nothing clears them but reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busCsWritten_ff <= 1'b0;
      stackWritten_ff <= 1'b0;
    end else begin
      busCsWritten_ff <= busCsWritten_ff | wrBusCs;
      stackWritten_ff <= stackWritten_ff | wrStack;
    end
  end

  wire intOpen = busCsWritten_ff && stackWritten_ff;

  // Request pin synchroniser: three stages, change taken when last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync_ff  <= 3'h7;
      reqLevel_ff <= 1'b1;
    end else begin
      reqSync_ff <= {reqSync_ff[1:0], busRequestIn_n};
      if (reqSync_ff[2] == reqSync_ff[1]) reqLevel_ff <= reqSync_ff[2];
    end
  end

  // Release only works when the pins exist and software enabled them
  wire relEnable = HAS_RELEASE && relWait_ff[REL_EN_POS];
  // The master keeps its request low until it sees the acknowledge, so a
  // simple level follower is enough here
  wire nxt_released = relEnable && !reqLevel_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) released_ff <= 1'b0;
    else        released_ff <= nxt_released;
  end

  // Read mux; unmapped addresses read zero
  wire [7:0] nxt_rdData = selBusCs ? busCs_ff :
                          selStack ? stackPage_ff :
                          selRel   ? relWait_ff : 8'h00;

  // Wait states: code times two, so zero gives none and seven gives fourteen
  wire [2:0] waitCode   = relWait_ff[WAIT_LO_POS +: 3];
  wire [3:0] waitStates = 4'({1'b0, waitCode} * WAIT_STEP);
  // Storage-only field decodes as the widest window
  wire [1:0] csModeEff  = CS_MODE_STORE ? 2'h3 : busCs_ff[CS_MODE_LO_POS +: 2];
  wire [1:0] busModeRaw = busCs_ff[BUS_MODE_LO_POS +: 2];
  // Single-chip bus mode forces chip selects off
  wire [3:0] csEnEff    = (busModeRaw == 2'h0) ? 4'h0 : busCs_ff[3:0];

  sys_cfg_t nxt_sysCfg;
  always_comb begin
    nxt_sysCfg.busMode    = bus_mode_t'(busModeRaw);
    nxt_sysCfg.csMode     = cs_mode_t'(csModeEff);
    nxt_sysCfg.csEnable   = csEnEff;
    nxt_sysCfg.stackPage  = stackPage_ff;
    nxt_sysCfg.waitStates = waitStates;
    nxt_sysCfg.clkSrcHs   = relWait_ff[CLK_SRC_POS];
    nxt_sysCfg.hsOscOn    = relWait_ff[HS_OSC_POS];
    nxt_sysCfg.voltMode   = relWait_ff[VOLT_LO_POS +: 2];
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData           <= 8'h00;
      intReqOut        <= 1'b0;
      nmiReqOut        <= 1'b0;
      busAck_n         <= 1'b1;
      internalMemBlock <= 1'b0;
      releasePinsUsed  <= 1'b0;
      sysCfg           <= '0;
    end else begin
      rdData           <= cpuReq.rd ? nxt_rdData : 8'h00;
      intReqOut        <= intOpen && intReqIn;
      nmiReqOut        <= intOpen && nmiReqIn;
      busAck_n         <= !nxt_released;
      internalMemBlock <= nxt_released;
      releasePinsUsed  <= relEnable;
      sysCfg           <= nxt_sysCfg;
    end
  end

  // Checks
  property p_int_blocked;
    @(posedge clk) disable iff (!rst_n)
      !(busCsWritten_ff && stackWritten_ff) |=> !intReqOut && !nmiReqOut;
  endproperty
  a_int_blocked: assert property (p_int_blocked) else $error("Interrupt passed before setup");

  property p_nmi_passes;
    @(posedge clk) disable iff (!rst_n)
      intOpen && nmiReqIn |=> nmiReqOut;
  endproperty
  a_nmi_passes: assert property (p_nmi_passes) else $error("Open NMI not passed");

  property p_int_passes;
    @(posedge clk) disable iff (!rst_n)
      intOpen && intReqIn |=> intReqOut;
  endproperty
  a_int_passes: assert property (p_int_passes) else $error("Open interrupt not passed");

  // Read data only stands in the cycle after a read
  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !cpuReq.rd |=> rdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Read data without read");

  // Write, one quiet cycle, then a read of the same register; compare with the written byte
  sequence s_stack_write_read;
    wrStack ##1 !cpuReq.wr ##1 (cpuReq.rd && selStack && !cpuReq.wr);
  endsequence
  property p_write_read;
    @(posedge clk) disable iff (!rst_n)
      s_stack_write_read |=> rdData == $past(cpuReq.wdata, 3);
  endproperty
  a_write_read: assert property (p_write_read) else $error("Read back mismatch");

  property p_unmapped_zero;
    @(posedge clk) disable iff (!rst_n)
      cpuReq.rd && !selBusCs && !selStack && !selRel |=> rdData == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero");

  sequence s_req_low;
    relEnable && !reqLevel_ff;
  endsequence
  property p_ack_low;
    @(posedge clk) disable iff (!rst_n)
      s_req_low |-> ##1 !busAck_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("Acknowledge not driven");

  property p_reclaim;
    @(posedge clk) disable iff (!rst_n)
      reqLevel_ff |-> ##1 busAck_n;
  endproperty
  a_reclaim: assert property (p_reclaim) else $error("Bus not reclaimed");

  property p_mem_block;
    @(posedge clk) disable iff (!rst_n)
      !busAck_n |-> internalMemBlock;
  endproperty
  a_mem_block: assert property (p_mem_block) else $error("Internal memory open while released");

  property p_wait_decode;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> sysCfg.waitStates == 4'($past(waitCode) * 2);
  endproperty
  a_wait_decode: assert property (p_wait_decode) else $error("Wait decode wrong");

  property p_no_release_pins;
    @(posedge clk) disable iff (!rst_n)
      !HAS_RELEASE |-> busAck_n && !releasePinsUsed;
  endproperty
  a_no_release_pins: assert property (p_no_release_pins) else $error("Release on variant without it");

endmodule : system_bus_config_registers
`default_nettype wire

// ---- verification/bus_master_model.sv ----
/*
  External bus master model that asks the bank for the shared bus.
  Assumes the bank's clock and reset; the bench raises want to ask.
*/
`default_nettype none
module bus_master_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic want,
  input  wire logic busAck_n,
  output logic      busRequestIn_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dropping the request before the answer is undefined, so hold it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busRequestIn_n <= 1'b1;
    end else if (want) begin
      busRequestIn_n <= 1'b0;
    end else if (!busAck_n) begin
      busRequestIn_n <= 1'b1;
    end
  end
endmodule : bus_master_model
`default_nettype wire

// ---- verification/tb.sv ----
/*
  Self-checking bench for the configuration bank: CPU cycles, gate, release.
  Assumes default parameters: single-chip layout, release pins present, plus
  a processor-layout variant with storage-only mode field and no release pins.
*/
`default_nettype none
module tb;
  import sys_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk         = 1'b0;
  logic       rst_n       = 1'b0;
  cpu_req_t   cpuReq      = '0;
  logic       intReqIn    = 1'b0;
  logic       nmiReqIn    = 1'b0;
  logic       want        = 1'b0;
  logic       busReq_n;
  logic [7:0] rdData;
  logic       intReqOut;
  logic       nmiReqOut;
  logic       busAck_n;
  logic       memBlock;
  logic       pinsUsed;
  sys_cfg_t   sysCfg;
  logic [7:0] rdDataAlt;
  logic       ackAlt_n;
  logic       pinsUsedAlt;
  sys_cfg_t   sysCfgAlt;
  int         miscompares = 0;
  int         checksDone  = 0;
  int         mdl [3]     = '{8'h30, 8'h00, 8'h00};
  int         n;
  logic [7:0] d;

  system_bus_config_registers i_dut (.clk(clk), .rst_n(rst_n), .cpuReq(cpuReq), .rdData(rdData),
    .intReqIn(intReqIn), .nmiReqIn(nmiReqIn), .intReqOut(intReqOut), .nmiReqOut(nmiReqOut),
    .busRequestIn_n(busReq_n), .busAck_n(busAck_n), .internalMemBlock(memBlock),
    .releasePinsUsed(pinsUsed), .sysCfg(sysCfg));
  bus_master_model i_master (.clk(clk), .rst_n(rst_n), .want(want), .busAck_n(busAck_n),
    .busRequestIn_n(busReq_n));
  // Variant: processor layout, storage-only chip-select mode, no release pins
  system_bus_config_registers #(.PROC_MODE(1'b1), .CS_MODE_STORE(1'b1), .HAS_RELEASE(1'b0)) i_dutAlt (
    .clk(clk), .rst_n(rst_n), .cpuReq(cpuReq), .rdData(rdDataAlt), .intReqIn(intReqIn), .nmiReqIn(nmiReqIn),
    .intReqOut(), .nmiReqOut(), .busRequestIn_n(busReq_n), .busAck_n(ackAlt_n), .internalMemBlock(),
    .releasePinsUsed(pinsUsedAlt), .sysCfg(sysCfgAlt));

  // 10 MHz system clock
  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One byte write; the model follows every mapped write
  task automatic wr(input logic [23:0] a, input logic [7:0] v);
    @(posedge clk) cpuReq <= '{1'b0, 1'b1, a, v};
    @(posedge clk) cpuReq <= '0;
    if (a >= 24'h00FF00 && a <= 24'h00FF02) mdl[a - 24'h00FF00] = v;
  endtask : wr

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [23:0] a, output logic [7:0] q);
    @(posedge clk) cpuReq <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk) cpuReq <= '0;
    #1 q = rdData;
  endtask : rd

  task automatic results;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Whole run is under two hundred cycles; this cuts a hang short
  initial begin
    #2000000;
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(60));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(24'h00FF00 + i, d);
      chk(d, (i < 3) ? mdl[i][7:0] : 8'h00);
      chk(rdDataAlt, (i == 0) ? RST_BUS_CS_MPU : ((i < 3) ? mdl[i][7:0] : 8'h00));
    end
    $display("test reset done");
    @(posedge clk) {intReqIn, nmiReqIn} <= 2'b11;
    repeat (3) @(posedge clk);
    #1 chk({intReqOut, nmiReqOut}, 8'h00);
    wr(24'h00FF00, 8'h30);
    repeat (3) @(posedge clk);
    #1 chk({intReqOut, nmiReqOut}, 8'h00);
    wr(24'h00FF01, 8'($urandom));
    repeat (3) @(posedge clk);
    #1 chk({intReqOut, nmiReqOut}, 8'h03);
    @(posedge clk) {intReqIn, nmiReqIn} <= 2'b00;
    repeat (2) @(posedge clk);
    #1 chk({intReqOut, nmiReqOut}, 8'h00);
    $display("test gate done");
    for (int i = 0; i < 6; i++) begin
      n = $urandom % 3;
      wr(24'h00FF00 + n, 8'($urandom));
      rd(24'h00FF00 + n, d);
      chk(d, mdl[n][7:0]);
    end
    wr(24'h00FF03, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      rd(24'h00FF00 + i, d);
      chk(d, mdl[i][7:0]);
      chk(rdDataAlt, mdl[i][7:0]);
    end
    chk(sysCfg.stackPage, mdl[1][7:0]);
    // Mode field decodes here, but is plain storage in the variant
    wr(24'h00FF00, 8'h40);
    rd(24'h00FF00, d);
    chk(rdDataAlt, 8'h40);
    chk({6'h0, sysCfg.csMode}, 8'h00);
    chk({6'h0, sysCfgAlt.csMode}, 8'h03);
    $display("test access done");
    // Every wait code, release kept off
    for (int c = 0; c < 8; c++) begin
      wr(24'h00FF02, 8'(c << 4));
      @(posedge clk);
      #1 chk({4'h0, sysCfg.waitStates}, 8'(c * 2));
    end
    $display("test wait done");
    @(posedge clk) want <= 1'b1;
    repeat (10) @(posedge clk);
    want <= 1'b0;
    #1 chk(busAck_n, 1'b1);
    wr(24'h00FF02, 8'h80);
    // Look a little after each edge so the registered pin has settled
    for (n = 0; n < 12 && busAck_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk(busAck_n, 1'b0);
    chk(memBlock, 1'b1);
    chk(pinsUsed, 1'b1);
    chk(ackAlt_n, 1'b1);
    chk(pinsUsedAlt, 1'b0);
    for (n = 0; n < 12 && busAck_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(busAck_n, 1'b1);
    chk(memBlock, 1'b0);
    rd(24'h00FF02, d);
    chk(rdDataAlt, 8'h80);
    $display("test release done");
    // Mid-run reset: registers, written flags and the gate start over
    @(posedge clk) rst_n <= 1'b0;
    {intReqIn, nmiReqIn} <= 2'b11;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mdl = '{8'h30, 8'h00, 8'h00};
    wr(24'h00FF01, 8'h5A);
    rd(24'h00FF01, d);
    chk(d, mdl[1][7:0]);
    repeat (3) @(posedge clk);
    #1 chk({intReqOut, nmiReqOut}, 8'h00);
    chk(busAck_n, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(24'h00FF00 + i, d);
      chk(d, mdl[i][7:0]);
      chk(rdDataAlt, (i == 0) ? RST_BUS_CS_MPU : mdl[i][7:0]);
    end
    $display("test reset again done");
    results();
  end
endmodule : tb
`default_nettype wire
